//--- include/rtc_trim_map.svh
// How it works
// - trim applied to prescaler once per minute
// - apply at 512th oscillator edge after 59-00
// - sample signed trim, shift prescaler count
// - counting advances only while clk runs and module enabled
// - enabled alarm interrupt raises wake request
// - idle leaves counting, alarm, trim untouched
// - alarm window entry chosen by pointer
// - unimplemented bits ignore writes, read zero
// - config registers clear, value windows unknown
// - one trim unit equals four oscillator cycles
// - positive trim inserts counts, negative blanks
`ifndef RTC_TRIM_MAP_SVH
`define RTC_TRIM_MAP_SVH

// register byte offsets
`define OFS_ALARM_VALUE  8'h00
`define OFS_ALARM_CFG    8'h04
`define OFS_TIME_VALUE   8'h08
`define OFS_CLOCK_CFG    8'h0C
`define OFS_PAD_SETUP    8'h10
`define OFS_INT_STATUS   8'h14
`define OFS_INT_MASK     8'h18

// reset values of the configuration registers
`define CFG_RESET        16'h0000
`define PTR_RESET        2'h0
`define INT_RESET        3'h0

// bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// prescaler and calendar constants
`define PRESC_LAST       15'h7FFF
`define CAL_PRE_EDGE     15'h01FF
`define CAL_EDGE_COUNT   16'h0200
`define SYNC_START       15'h7FE0
`define BCD_LAST         8'h59
`define BCD_ZERO         8'h00
`define ALARM_MASK_ALL   4'h0

// clock configuration field positions
`define CLK_EN_BIT       15
`define CLK_WREN_BIT     13
`define CLK_OE_BIT       10
`define CLK_PTR          9:8
`define CLK_TRIM         7:0

// alarm configuration field positions
`define ALM_EN_BIT       15
`define ALM_FOREVER_BIT  14
`define ALM_MASK         13:10
`define ALM_PTR          9:8
`define ALM_REPEAT       7:0

// pad setup field positions and half-second bit of the prescaler
`define PAD_SEL_BIT      1
`define PAD_LEVEL_BIT    0
`define HALF_SEC_BIT     14

// interrupt status bit positions
`define INT_ALARM        0
`define INT_SECOND       1
`define INT_CAL          2

`endif

//--- include/rtc_trim_pkg.sv
package rtc_trim_pkg;

   // master to slave half of the lite register bus
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axilReq_t;

   // slave to master half of the lite register bus
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axilRsp_t;

endpackage : rtc_trim_pkg

//--- testbench/rtc_drift_trim_asserts.sv
`timescale 1ns/1ps
module rtc_drift_trim_asserts import rtc_trim_pkg::*; (
   // clock and reset
   input wire logic     clk,
   input wire logic     rst,
   // watched ports
   input wire axilReq_t busReq,
   input wire axilRsp_t busRsp,
   input wire logic     oscPin,
   input wire logic     irq,
   input wire logic     wakeRequest,
   input wire logic     clockOut,
   input wire logic     clockOutEn,
   input wire logic     padInputLevel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   reset_quiet_a: assert property (
      $fell(rst) |-> !(irq | wakeRequest | clockOut | clockOutEn | padInputLevel))
      else $error("outputs active after reset");
   wake_needs_irq_a: assert property (wakeRequest |-> irq)
      else $error("wake without interrupt");
   read_upper_zero_a: assert property (
      busRsp.rvalid |-> busRsp.rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   error_read_zero_a: assert property (
      busRsp.rvalid && busRsp.rresp == 2'h2 |-> busRsp.rdata == 32'h0000_0000)
      else $error("refused read returned data");
   out_enable_write_a: assert property (
      $changed(clockOutEn) |-> $past(busRsp.bvalid))
      else $error("output enable moved without write");
   pad_level_write_a: assert property (
      $changed(padInputLevel) |-> $past(busRsp.bvalid))
      else $error("pad level moved without write");
   wake_sticky_a: assert property ($fell(wakeRequest) |-> $past(busRsp.bvalid))
      else $error("wake dropped without write");
   irq_sticky_a: assert property ($fell(irq) |-> $past(busRsp.bvalid, 1))
      else $error("interrupt dropped without write");
endmodule : rtc_drift_trim_asserts

bind rtc_drift_trim rtc_drift_trim_asserts rtc_drift_trim_asserts_inst (
   .clk(clk), .rst(rst), .busReq(busReq), .busRsp(busRsp), .oscPin(oscPin), .irq(irq),
   .wakeRequest(wakeRequest), .clockOut(clockOut), .clockOutEn(clockOutEn),
   .padInputLevel(padInputLevel));

//--- testbench/test_rtc_drift_trim.sv
`timescale 1ns/1ps
module test_rtc_drift_trim import rtc_trim_pkg::*; ;
   typedef struct packed {logic [7:0] a; logic [31:0] d, e; logic [1:0] s;} row_t;
   logic        clk, rst, oscPin, irq, wakeRequest, clockOut, clockOutEn, padInputLevel;
   axilReq_t    busReq;
   axilRsp_t    busRsp;
   int          num_errors, checks_done, k;
   logic [31:0] v;
   logic [1:0]  r;
   // address, write, expected read, expected answer
   row_t        rows [5] = '{'{8'h04, 32'hFFFFFFFF, 32'h0000FFFF, 2'h0},
                             '{8'h10, 32'hFFFFFFFF, 32'h00000003, 2'h0},
                             '{8'h0C, 32'h00007FFF, 32'h000027FF, 2'h0},
                             '{8'h18, 32'hFFFFFFFF, 32'h00000007, 2'h0},
                             '{8'h1C, 32'h12345678, 32'h00000000, 2'h2}};
   logic [7:0]  cfgs [3] = '{8'h04, 8'h0C, 8'h10};

   rtc_drift_trim rtc_drift_trim_inst (.clk(clk), .rst(rst), .busReq(busReq),
      .busRsp(busRsp), .oscPin(oscPin), .irq(irq), .wakeRequest(wakeRequest),
      .clockOut(clockOut), .clockOutEn(clockOutEn), .padInputLevel(padInputLevel));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // write cycle, each channel released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
      busReq.awaddr  <= a;
      busReq.wdata   <= d;
      busReq.awvalid <= 1'b1;
      busReq.wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (busRsp.awready) busReq.awvalid <= 1'b0;
         if (busRsp.wready) busReq.wvalid <= 1'b0;
      end while (!busRsp.bvalid);
      s = busRsp.bresp;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
      busReq.araddr  <= a;
      busReq.arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (busRsp.arready) busReq.arvalid <= 1'b0;
      end while (!busRsp.rvalid);
      d = busRsp.rdata;
      s = busRsp.rresp;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  s;
      rd(a, d, s);
      chk(d, e);
   endtask : rc
   // one oscillator rising edge, one clock high; pin moves on the clock edge
   task automatic osc(input int lo);
      oscPin <= 1'b1;
      @(posedge clk);
      oscPin <= 1'b0;
      repeat (lo) @(posedge clk);
   endtask : osc
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////
   initial begin
      // tests need about 69k cycles, mostly the first second of edges
      repeat (90000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial begin
      busReq = '0;
      busReq.wstrb = 4'hF;
      busReq.bready = 1'b1;
      busReq.rready = 1'b1;
      rst = 1'b1;
      oscPin = 1'b0;
      num_errors = 0;
      checks_done = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r);
         chk(r, rows[i].s);
         rd(rows[i].a, v, r);
         chk(v, rows[i].e);
         chk(r, rows[i].s);
      end
      chk({clockOutEn, padInputLevel}, 2'b11);
      $display("register rows done");
      // second reset in mid-run
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (cfgs[i]) rc(cfgs[i], 32'h0);
      $display("reset values done");
      wr(8'h04, 32'h0200, r);
      for (k = 0; k < 3; k++) wr(8'h00, 32'h111 * (k + 1), r);
      wr(8'h04, 32'h0200, r);
      for (k = 0; k < 3; k++) rc(8'h00, 32'h111 * (k + 1));
      $display("alarm window done");
      // time 00:59, seconds clock out, alarm every second, trim -3
      wr(8'h0C, 32'h2000, r);
      wr(8'h08, 32'h0059, r);
      wr(8'h10, 32'h0002, r);
      wr(8'h04, 32'hC000, r);
      wr(8'h18, 32'h0004, r);
      wr(8'h0C, 32'hA0FD, r);
      // two clocks per edge keeps the first second inside the run limit
      for (k = 0; k < 32700; k++) osc(1);
      k = 0;
      while (!clockOut && k < 2000) begin
         osc(4);
         k++;
      end
      k = 0;
      while (irq !== 1'b1 && k < 600) begin
         osc(4);
         k++;
      end
      chk(k, 512);
      rc(8'h08, 32'h0100);
      rc(8'h0C, 32'hA0FD);
      rc(8'h14, 32'h0007);
      wr(8'h18, 32'h0005, r);
      repeat (2) @(posedge clk);
      chk({irq, wakeRequest}, 2'b11);
      wr(8'h14, 32'h0007, r);
      repeat (2) @(posedge clk);
      chk({irq, wakeRequest}, 2'b00);
      rc(8'h14, 32'h0000);
      $display("calibration and interrupt done");
      summarize();
   end
endmodule : test_rtc_drift_trim

//--- verilog/axil_slave.sv
`timescale 1ns/1ps
`include "rtc_trim_map.svh"

module axil_slave import rtc_trim_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bus
   input  wire axilReq_t    req,
   output axilRsp_t         rsp,
   // register side
   output logic             wrEn,
   output logic [7:0]       wrAddr,
   output logic [31:0]      wrData,
   output logic [3:0]       wrStrb,
   input  wire logic        wrErr,
   output logic             rdEn,
   output logic [7:0]       rdAddr,
   input  wire logic [31:0] rdData,
   input  wire logic        rdErr
);

   logic        awHeld;    // write address captured
   logic        wHeld;     // write data captured
   logic        bValid;    // write answer waiting
   logic [1:0]  bResp;     // write answer code
   logic        rValid;    // read answer waiting
   logic [31:0] readData;  // read word held for the master
   logic [1:0]  rResp;     // read answer code
   logic        awReady;   // address channel open
   logic        wReady;    // data channel open
   logic        arReady;   // read address channel open

   // ready while nothing is held and no answer waits
   assign awReady = ~awHeld & ~bValid;
   assign wReady  = ~wHeld & ~bValid;
   assign arReady = ~rValid;
   assign wrEn    = awHeld & wHeld & ~bValid;
   assign rdEn    = req.arvalid & arReady;
   assign rdAddr  = req.araddr;

   // one driver for the whole answer, so no field has two sources
   assign rsp = '{awready: awReady, wready: wReady, bvalid: bValid, bresp: bResp,
                  arready: arReady, rvalid: rValid, rdata: readData, rresp: rResp};

   ////////////////////////////////////////////////////////////////////////////////
   // write channels, taken in either order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHeld     <= 1'b0;
         wHeld      <= 1'b0;
         wrAddr     <= 8'h00;
         wrData     <= 32'h0000_0000;
         wrStrb     <= 4'h0;
         bValid     <= 1'b0;
         bResp      <= `RESP_OKAY;
      end else begin
         if (req.awvalid && awReady) begin       // address taken
            awHeld <= 1'b1;
            wrAddr <= req.awaddr;
         end
         if (req.wvalid && wReady) begin         // data taken
            wHeld  <= 1'b1;
            wrData <= req.wdata;
            wrStrb <= req.wstrb;
         end
         if (wrEn) begin                         // both held: commit, answer
            awHeld     <= 1'b0;
            wHeld      <= 1'b0;
            bValid     <= 1'b1;
            bResp      <= wrErr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bValid && req.bready) begin
            bValid     <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read channel, data registered one cycle after the address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rValid   <= 1'b0;
         readData <= 32'h0000_0000;
         rResp    <= `RESP_OKAY;
      end else if (rdEn) begin
         rValid   <= 1'b1;
         readData <= rdData;
         rResp    <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (rValid && req.rready) begin
         rValid   <= 1'b0;
      end
   end

endmodule : axil_slave

//--- verilog/pin_sync.sv
`timescale 1ns/1ps

module pin_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pin side
   input  wire logic pin,
   // synchronous side
   output logic      level,
   output logic      rise
);

   logic meta;   // first stage, read only by second
   logic prev;   // delayed level for edge detect

   ////////////////////////////////////////////////////////////////////////////////
   // two flops, then an edge detector on the clean level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta  <= 1'b0;
         level <= 1'b0;
         prev  <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;   // one-cycle pulse per rising edge

endmodule : pin_sync

//--- verilog/rtc_drift_trim.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rtc_trim_map.svh"

module rtc_drift_trim import rtc_trim_pkg::*; (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // register bus
   input  wire axilReq_t busReq,
   output axilRsp_t      busRsp,
   // secondary oscillator pin
   input  wire logic     oscPin,
   // interrupt and wake
   output logic          irq,
   output logic          wakeRequest,
   // clock output pin and pad control
   output logic          clockOut,
   output logic          clockOutEn,
   output logic          padInputLevel
);

   ////////////////////////////////////////////////////////////////////////////////
   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [15:0] res;
      res[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      res[15:8] = strb[1] ? data[15:8] : old[15:8];
      return res;
   endfunction : mergeBytes

   // two-digit bcd increment wrapping 59 to 00
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      logic [7:0] res;
      res = v + 8'h01;
      if (v == `BCD_LAST) begin
         res = `BCD_ZERO;
      end else if (v[3:0] == 4'h9) begin
         res = {v[7:4] + 4'h1, 4'h0};
      end
      return res;
   endfunction : bcdInc

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave and register strobes
   logic        wrEn;          // write commit pulse
   logic [7:0]  wrAddr;        // write byte address
   logic [31:0] wrData;        // write data
   logic [3:0]  wrStrb;        // write byte enables
   logic        rdEn;          // read accept pulse
   logic [7:0]  rdAddr;        // read byte address
   logic [31:0] rdData;        // read data toward slave
   logic        wrErr;         // unmapped write
   logic        rdErr;         // unmapped read

   axil_slave busPort (
      .clk    (clk),
      .rst    (rst),
      .req    (busReq),
      .rsp    (busRsp),
      .wrEn   (wrEn),
      .wrAddr (wrAddr),
      .wrData (wrData),
      .wrStrb (wrStrb),
      .wrErr  (wrErr),
      .rdEn   (rdEn),
      .rdAddr (rdAddr),
      .rdData (rdData),
      .rdErr  (rdErr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // oscillator pin synchroniser
   logic oscRise;    // one pulse per oscillator edge

   pin_sync oscSync (
      .clk   (clk),
      .rst   (rst),
      .pin   (oscPin),
      .level (),
      .rise  (oscRise)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // register state
   logic        moduleEnable;        // clock_module_enable
   logic        writeEnable;         // clock_write_enable
   logic        outputEnable;        // clock_output_enable
   logic [1:0]  timePtr;             // time_window_pointer
   logic [7:0]  trim;                // signed drift trim
   logic        alarmEnable;         // alarm_enable
   logic        repeatForever;       // repeat without end
   logic [3:0]  compareMask;         // alarm_compare_mask
   logic [1:0]  alarmPtr;            // alarm_window_pointer
   logic [7:0]  repeatCount;         // alarm_repeat_count
   logic        outputSourceSelect;  // output_source_select
   logic        parallelPortLevel;   // parallel_port_input_level
   logic [2:0]  intStatus;           // sticky event bits
   logic [2:0]  intMask;             // interrupt enables
   logic [15:0] timeWin  [4];        // time value pairs, not reset
   logic [15:0] alarmWin [4];        // alarm value pairs, not reset

   // counting state
   logic [14:0] prescaler;           // oscillator edges within the second
   logic        calArmed;            // waiting for the correction point
   logic        alarmCheck;          // compare slot after a tick
   logic        alarmToggle;         // alarm square wave

   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   wire hitAlarmVal  = wrEn && (wrAddr == `OFS_ALARM_VALUE);
   wire hitAlarmCfg  = wrEn && (wrAddr == `OFS_ALARM_CFG);
   wire hitTimeVal   = wrEn && (wrAddr == `OFS_TIME_VALUE);
   wire hitClockCfg  = wrEn && (wrAddr == `OFS_CLOCK_CFG);
   wire hitPad       = wrEn && (wrAddr == `OFS_PAD_SETUP);
   wire hitIntStat   = wrEn && (wrAddr == `OFS_INT_STATUS);
   wire hitIntMask   = wrEn && (wrAddr == `OFS_INT_MASK);
   wire rdAlarmVal   = rdEn && (rdAddr == `OFS_ALARM_VALUE);
   wire rdTimeVal    = rdEn && (rdAddr == `OFS_TIME_VALUE);

   // unmapped addresses answer with an error
   assign wrErr = ~(hitAlarmVal | hitAlarmCfg | hitTimeVal | hitClockCfg
                    | hitPad | hitIntStat | hitIntMask);
   wire rdMapped = (rdAddr == `OFS_ALARM_VALUE) || (rdAddr == `OFS_ALARM_CFG)
                || (rdAddr == `OFS_TIME_VALUE)  || (rdAddr == `OFS_CLOCK_CFG)
                || (rdAddr == `OFS_PAD_SETUP)   || (rdAddr == `OFS_INT_STATUS)
                || (rdAddr == `OFS_INT_MASK);
   assign rdErr = ~rdMapped;

   ////////////////////////////////////////////////////////////////////////////////
   // live status bits
   wire halfSecond    = prescaler[`HALF_SEC_BIT];       // second half of the second
   wire rolloverSync  = prescaler >= `SYNC_START;       // rollover is near
   wire secTick       = moduleEnable && oscRise && (prescaler == `PRESC_LAST);
   wire secWrap       = secTick && (timeWin[0][7:0] == `BCD_LAST);
   wire calPoint      = calArmed && moduleEnable && oscRise
                        && (prescaler == `CAL_PRE_EDGE);

   // signed trim times four as a prescaler offset
   wire [15:0] trimStep  = {{6{trim[7]}}, trim, 2'b00};
   wire [15:0] calTarget = `CAL_EDGE_COUNT + trimStep;

   // register images, unimplemented bits fixed at zero
   wire [15:0] clockImage = {moduleEnable, 1'b0, writeEnable, rolloverSync,
                             halfSecond, outputEnable, timePtr, trim};
   wire [15:0] alarmImage = {alarmEnable, repeatForever, compareMask,
                             alarmPtr, repeatCount};
   wire [15:0] padImage   = {14'h0000, outputSourceSelect, parallelPortLevel};

   // merged write values
   wire [15:0] clockNew = mergeBytes(clockImage, wrData, wrStrb);
   wire [15:0] alarmNew = mergeBytes(alarmImage, wrData, wrStrb);
   wire [15:0] padNew   = mergeBytes(padImage, wrData, wrStrb);

   // fields of the merged write words
   wire       newModuleEnable  = clockNew[`CLK_EN_BIT];
   wire       newWriteEnable   = clockNew[`CLK_WREN_BIT];
   wire       newOutputEnable  = clockNew[`CLK_OE_BIT];
   wire [1:0] newTimePtr       = clockNew[`CLK_PTR];
   wire [7:0] newTrim          = clockNew[`CLK_TRIM];
   wire       newAlarmEnable   = alarmNew[`ALM_EN_BIT];
   wire       newRepeatForever = alarmNew[`ALM_FOREVER_BIT];
   wire [3:0] newCompareMask   = alarmNew[`ALM_MASK];
   wire [1:0] newAlarmPtr      = alarmNew[`ALM_PTR];
   wire [7:0] newRepeatCount   = alarmNew[`ALM_REPEAT];
   wire       newSourceSelect  = padNew[`PAD_SEL_BIT];
   wire       newPortLevel     = padNew[`PAD_LEVEL_BIT];

   // alarm match after the second has updated
   wire alarmMatch = (compareMask == `ALARM_MASK_ALL) || (alarmWin[0] == timeWin[0]);
   wire alarmEvent = alarmCheck && alarmEnable && alarmMatch;

   // window accesses step the pointer down toward zero
   wire timeAccess  = rdTimeVal || (hitTimeVal && writeEnable);
   wire alarmAccess = rdAlarmVal || hitAlarmVal;

   ////////////////////////////////////////////////////////////////////////////////
   // read data mux, upper half always zero
   wire [15:0] rdLow =
      (rdAddr == `OFS_ALARM_VALUE) ? alarmWin[alarmPtr] :
      (rdAddr == `OFS_ALARM_CFG)   ? alarmImage :
      (rdAddr == `OFS_TIME_VALUE)  ? timeWin[timePtr] :
      (rdAddr == `OFS_CLOCK_CFG)   ? clockImage :
      (rdAddr == `OFS_PAD_SETUP)   ? padImage :
      (rdAddr == `OFS_INT_STATUS)  ? {13'h0000, intStatus} :
      (rdAddr == `OFS_INT_MASK)    ? {13'h0000, intMask} : 16'h0000;
   assign rdData = {16'h0000, rdLow};

   ////////////////////////////////////////////////////////////////////////////////
   // clock configuration register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         moduleEnable <= 1'b0;
         writeEnable  <= 1'b0;
         outputEnable <= 1'b0;
         timePtr      <= `PTR_RESET;
         trim         <= 8'h00;
      end else if (hitClockCfg) begin          // software write, status bits dropped
         moduleEnable <= newModuleEnable;
         writeEnable  <= newWriteEnable;
         outputEnable <= newOutputEnable;
         timePtr      <= newTimePtr;
         trim         <= newTrim;
      end else if (timeAccess && (timePtr != `PTR_RESET)) begin
         timePtr      <= timePtr - 2'h1;       // walk toward the seconds pair
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // alarm configuration register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarmEnable   <= 1'b0;
         repeatForever <= 1'b0;
         compareMask   <= 4'h0;
         alarmPtr      <= `PTR_RESET;
         repeatCount   <= 8'h00;
      end else if (hitAlarmCfg) begin          // software write
         alarmEnable   <= newAlarmEnable;
         repeatForever <= newRepeatForever;
         compareMask   <= newCompareMask;
         alarmPtr      <= newAlarmPtr;
         repeatCount   <= newRepeatCount;
      end else begin
         if (alarmAccess && (alarmPtr != `PTR_RESET)) begin
            alarmPtr <= alarmPtr - 2'h1;       // walk toward the seconds pair
         end
         if (alarmEvent) begin                 // repeat bookkeeping
            if (!repeatForever && (repeatCount == 8'h00)) begin
               alarmEnable <= 1'b0;            // last repeat done
            end else begin
               repeatCount <= repeatCount - 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pad setup and interrupt registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outputSourceSelect <= 1'b0;
         parallelPortLevel  <= 1'b0;
         intMask            <= `INT_RESET;
      end else begin
         if (hitPad) begin
            outputSourceSelect <= newSourceSelect;
            parallelPortLevel  <= newPortLevel;
         end
         if (hitIntMask && wrStrb[0]) begin
            intMask <= wrData[2:0];
         end
      end
   end

   // sticky events, a new event beats a clear in the same cycle
   wire [2:0] intClear = (hitIntStat && wrStrb[0]) ? wrData[2:0] : `INT_RESET;
   wire [2:0] intSet;
   assign intSet[`INT_ALARM]  = alarmEvent;
   assign intSet[`INT_SECOND] = secTick;
   assign intSet[`INT_CAL]    = calPoint;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         intStatus <= `INT_RESET;
      end else begin
         intStatus <= (intStatus & ~intClear) | intSet;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler with once-a-minute correction; counts synchronised oscillator edges on clk,
   // so it advances only while clk runs and moduleEnable is set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prescaler <= 15'h0000;
         calArmed  <= 1'b0;
      end else begin
         if (calPoint) begin                   // 512th edge after 59 to 00
            prescaler <= calTarget[14:0];
            calArmed  <= 1'b0;
         end else if (moduleEnable && oscRise) begin
            prescaler <= prescaler + 15'h0001; // wraps to zero at the tick
         end
         if (secWrap) begin
            calArmed <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // time value windows: no reset, contents unknown until written
   always_ff @(posedge clk) begin
      if (hitTimeVal && writeEnable) begin     // software write wins over a tick
         timeWin[timePtr] <= mergeBytes(timeWin[timePtr], wrData, wrStrb);
      end else if (secTick) begin              // seconds, minutes carry on wrap
         timeWin[0][7:0] <= bcdInc(timeWin[0][7:0]);
         if (secWrap) begin
            timeWin[0][15:8] <= bcdInc(timeWin[0][15:8]);
         end
      end
   end

   // alarm value windows: pointer selects the pair
   always_ff @(posedge clk) begin
      if (hitAlarmVal) begin
         alarmWin[alarmPtr] <= mergeBytes(alarmWin[alarmPtr], wrData, wrStrb);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // alarm compare slot and output pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarmCheck  <= 1'b0;
         alarmToggle <= 1'b0;
         clockOut    <= 1'b0;
         clockOutEn  <= 1'b0;
      end else begin
         alarmCheck <= secTick;                // compare once the second is updated
         if (alarmEvent) begin
            alarmToggle <= ~alarmToggle;       // half the alarm rate
         end
         clockOut   <= outputSourceSelect ? ~halfSecond : alarmToggle;
         clockOutEn <= outputEnable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt, wake and pad outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq           <= 1'b0;
         wakeRequest   <= 1'b0;
         padInputLevel <= 1'b0;
      end else begin
         irq           <= |(intStatus & intMask);
         wakeRequest   <= intStatus[`INT_ALARM] & intMask[`INT_ALARM];
         padInputLevel <= parallelPortLevel;
      end
   end

endmodule : rtc_drift_trim
